// ---- src/ppc_defines.vh ----
// constants for the priority pin crossbar: slots, config bits, resets
// assumes inclusion by the allocator and crossbar design files, by bare name
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH

// ----------------------------------------
// geometry
// ----------------------------------------
`define PPC_NUM_SLOTS 28
`define PPC_LOW_PINS 32
`define PPC_ALL_PINS 64
`define PPC_P1_BASE 8

// ----------------------------------------
// crossbar_config_0/1/2 bit positions
// ----------------------------------------
`define PPC_X0_SMBUS 0
`define PPC_X0_SPI 1
`define PPC_X0_SERIAL0 2
`define PPC_X0_PCA_LSB 3
`define PPC_X0_ECI 6
`define PPC_X0_CP0 7
`define PPC_X1_CP1 0
`define PPC_X1_T0 1
`define PPC_X1_INT0 2
`define PPC_X1_T1 3
`define PPC_X1_INT1 4
`define PPC_X1_T2 5
`define PPC_X1_T2EX 6
`define PPC_X1_SYSCLK 7
`define PPC_X2_CONV_START 0
`define PPC_X2_XMEM_LOW 1
`define PPC_X2_SERIAL1 2
`define PPC_X2_T4 3
`define PPC_X2_T4EX 4
`define PPC_X2_XBAR_EN 6
`define PPC_X2_WEAK_PUD 7

// ----------------------------------------
// slot kinds, slot index = priority
// ----------------------------------------
`define PPC_SLOT_IN_MASK 28'h0bfc8222
`define PPC_SLOT_OD_MASK 28'h00000c0
`define PPC_PCA_MAX 3'h5

// ----------------------------------------
// memory interface strobe pins
// ----------------------------------------
`define PPC_XMEM_WR_LO 7
`define PPC_XMEM_RD_LO 6
`define PPC_XMEM_ALE_LO 5
`define PPC_XMEM_WR_UP 39
`define PPC_XMEM_RD_UP 38
`define PPC_XMEM_ALE_UP 37

// ----------------------------------------
// reset values
// ----------------------------------------
`define PPC_LATCH_RESET 64'hffffffffffffffff
`define PPC_SYNC_RESET 64'hffffffffffffffff

`endif

// ---- src/ppc_alloc.v ----
// priority allocator: ranks enabled slots onto free lower pins
// assumes enables and availability from logic on the same clock
`include "ppc_defines.vh"
`timescale 1ns/1ns
module ppc_alloc #(
  parameter NS = `PPC_NUM_SLOTS,
  parameter NP = `PPC_LOW_PINS
) (
  input wire sys_clk,
  input wire rst,
  input wire [NS-1:0] slot_en,
  input wire [NP-1:0] pin_avail,
  output reg [NP-1:0] pin_owned,
  output reg [NP*5-1:0] pin_slot,
  output reg [NS*5-1:0] slot_pin,
  output reg [NS-1:0] slot_placed
);

reg [5:0] srank [0:NS-1];
reg [5:0] prank [0:NP-1];
reg [5:0] cnt;
reg [5:0] acnt;
reg [NP-1:0] next_owned;
reg [NP*5-1:0] next_pin_slot;
reg [NS*5-1:0] next_slot_pin;
reg [NS-1:0] next_placed;
integer s;
integer p;

// ----------------------------------------
// rank match: n-th enabled slot on n-th free pin
// ----------------------------------------
always @* begin
  cnt = 6'h00;
  acnt = 6'h00;
  next_owned = {NP{1'b0}};
  next_pin_slot = {NP*5{1'b0}};
  next_slot_pin = {NS*5{1'b0}};
  next_placed = {NS{1'b0}};
  for (s = 0; s < NS; s = s + 1) begin
    srank[s] = cnt;
    if (slot_en[s]) begin
      cnt = cnt + 6'h01;
    end
  end
  for (p = 0; p < NP; p = p + 1) begin
    prank[p] = acnt;
    if (pin_avail[p]) begin
      acnt = acnt + 6'h01;
    end
  end
  for (p = 0; p < NP; p = p + 1) begin
    for (s = 0; s < NS; s = s + 1) begin
      if (pin_avail[p] && slot_en[s] && srank[s] == prank[p]) begin
        next_owned[p] = 1'b1;
        next_pin_slot[p*5 +: 5] = s[4:0];
        next_slot_pin[s*5 +: 5] = p[4:0];
        next_placed[s] = 1'b1;
      end
    end
  end
end

// slots beyond the last pin simply stay unplaced
always @(posedge sys_clk) begin
  if (rst) begin
    pin_owned <= {NP{1'b0}};
    pin_slot <= {NP*5{1'b0}};
    slot_pin <= {NS*5{1'b0}};
    slot_placed <= {NS{1'b0}};
  end else begin
    pin_owned <= next_owned;
    pin_slot <= next_pin_slot;
    slot_pin <= next_slot_pin;
    slot_placed <= next_placed;
  end
end

endmodule // ppc_alloc

// ---- src/ppc_pin_cell.v ----
// one port pin output stage: mode, gate and weak pull-up
// assumes drive requests from logic on the same clock
`timescale 1ns/1ns
module ppc_pin_cell (
  input wire sys_clk,
  input wire rst,
  input wire drv_val,
  input wire drv_req,
  input wire drv_od,
  input wire drv_gate,
  input wire pu_disable,
  input wire analog,
  output reg pad_out,
  output reg pad_oe,
  output reg pad_pullup
);

reg next_oe;
reg next_out;

always @* begin
  // open drain only pulls low, high means released
  next_oe = drv_gate & drv_req & (drv_od ? ~drv_val : 1'b1);
  next_out = drv_od ? 1'b0 : drv_val;
end

always @(posedge sys_clk) begin
  if (rst) begin
    pad_out <= 1'b1;
    pad_oe <= 1'b0;
    pad_pullup <= 1'b1;
  end else begin
    pad_out <= next_out;
    pad_oe <= next_oe;
    // no fight with its own low drive
    pad_pullup <= ~pu_disable & ~analog & ~(next_oe & ~next_out);
  end
end

endmodule // ppc_pin_cell

// ---- src/ppc_crossbar.v ----
// priority pin crossbar with port data latches for ports 0 to 7
// assumes pad_in asynchronous; all other inputs on sys_clk
`include "ppc_defines.vh"
`timescale 1ns/1ns
module ppc_crossbar (
  input wire sys_clk,
  input wire rst,
  input wire [7:0] crossbar_config_0,
  input wire [7:0] crossbar_config_1,
  input wire [7:0] crossbar_config_2,
  input wire [63:0] port_pushpull,
  input wire [7:0] port1_digital_in,
  input wire ext_mem_enable,
  input wire ext_mem_muxed,
  input wire ext_mem_wr_n,
  input wire ext_mem_rd_n,
  input wire ext_mem_ale,
  input wire wr_en,
  input wire [2:0] wr_port,
  input wire wr_bit_mode,
  input wire [2:0] wr_bit_sel,
  input wire [7:0] wr_data,
  input wire rd_en,
  input wire [2:0] rd_port,
  input wire rd_bit_mode,
  input wire [2:0] rd_bit_sel,
  input wire rd_rmw,
  output reg [7:0] rd_data,
  output reg rd_valid,
  input wire [27:0] periph_out,
  input wire [27:0] periph_drive,
  output reg [27:0] periph_in,
  output reg [27:0] periph_routed,
  output reg [7:0] second_adc_ain_sel,
  input wire [63:0] pad_in,
  output wire [63:0] pad_out,
  output wire [63:0] pad_oe,
  output wire [63:0] pad_pullup
);

// ----------------------------------------
// declarations
// ----------------------------------------
wire [27:0] in_mask;
wire [27:0] od_mask;
wire xbar_en;
wire xmem_low;
wire pu_disable;
wire [2:0] pca_cnt;
wire [27:0] slot_en;
wire [31:0] pin_avail;
wire [31:0] pin_owned;
wire [159:0] pin_slot;
wire [139:0] slot_pin;
wire [27:0] slot_placed;
wire [63:0] pin_read;
wire [63:0] analog_pins;
wire [63:0] wdata_vec;
wire [63:0] wmask;
wire [7:0] rd_byte;
reg [63:0] latch;
reg [63:0] sync1;
reg [63:0] sync2;
reg [63:0] sync3;
reg [63:0] pin_state;
reg [63:0] next_pin_state;
reg [63:0] next_latch;
reg [63:0] xmem_here;
reg [63:0] xmem_val;
reg [63:0] drv_val;
reg [63:0] drv_req;
reg [63:0] drv_od;
reg [63:0] drv_gate;
reg [27:0] next_periph_in;
reg [4:0] sl;
reg own;
integer p;
integer s;

assign in_mask = `PPC_SLOT_IN_MASK;
assign od_mask = `PPC_SLOT_OD_MASK;
assign xbar_en = crossbar_config_2[`PPC_X2_XBAR_EN];
assign xmem_low = crossbar_config_2[`PPC_X2_XMEM_LOW];
assign pu_disable = crossbar_config_2[`PPC_X2_WEAK_PUD];

// ----------------------------------------
// helpers
// ----------------------------------------
function [7:0] byte_of;
  input [63:0] v;
  input [2:0] port;
  begin
    byte_of = v[{port, 3'h0} +: 8];
  end
endfunction

function [63:0] write_mask;
  input [2:0] port;
  input bit_mode;
  input [2:0] bsel;
  reg [63:0] m;
  begin
    m = 64'h0000000000000000;
    if (!bit_mode) begin
      m[{port, 3'h0} +: 8] = 8'hff;
    end else if (port < 3'h4) begin
      // upper ports take no bit access, the write is dropped
      m[{port, bsel}] = 1'b1;
    end
    write_mask = m;
  end
endfunction

// ----------------------------------------
// slot enables, in priority order
// ----------------------------------------
// pca field above its limit saturates rather than aliasing
assign pca_cnt = (crossbar_config_0[`PPC_X0_PCA_LSB +: 3] > `PPC_PCA_MAX) ?
  `PPC_PCA_MAX : crossbar_config_0[`PPC_X0_PCA_LSB +: 3];

// whole serial peripherals share one enable each
assign slot_en[1:0] = {2{crossbar_config_0[`PPC_X0_SERIAL0]}};
assign slot_en[5:2] = {4{crossbar_config_0[`PPC_X0_SPI]}};
assign slot_en[7:6] = {2{crossbar_config_0[`PPC_X0_SMBUS]}};
assign slot_en[9:8] = {2{crossbar_config_2[`PPC_X2_SERIAL1]}};

genvar g;
generate
  for (g = 0; g < 5; g = g + 1) begin : g_pca
    assign slot_en[10+g] = (pca_cnt > g);
  end
endgenerate

assign slot_en[15] = crossbar_config_0[`PPC_X0_ECI];
assign slot_en[16] = crossbar_config_0[`PPC_X0_CP0];
assign slot_en[17] = crossbar_config_1[`PPC_X1_CP1];
assign slot_en[18] = crossbar_config_1[`PPC_X1_T0];
assign slot_en[19] = crossbar_config_1[`PPC_X1_INT0];
assign slot_en[20] = crossbar_config_1[`PPC_X1_T1];
assign slot_en[21] = crossbar_config_1[`PPC_X1_INT1];
assign slot_en[22] = crossbar_config_1[`PPC_X1_T2];
assign slot_en[23] = crossbar_config_1[`PPC_X1_T2EX];
assign slot_en[24] = crossbar_config_2[`PPC_X2_T4];
assign slot_en[25] = crossbar_config_2[`PPC_X2_T4EX];
assign slot_en[26] = crossbar_config_1[`PPC_X1_SYSCLK];
assign slot_en[27] = crossbar_config_2[`PPC_X2_CONV_START];

// ----------------------------------------
// pin availability and allocation
// ----------------------------------------
assign analog_pins = {48'h000000000000, ~port1_digital_in, 8'h00};

// analog port 1 pins and reserved strobe pins are skipped
assign pin_avail[4:0] = 5'h1f;
assign pin_avail[`PPC_XMEM_ALE_LO] = ~(xmem_low & ext_mem_muxed);
assign pin_avail[`PPC_XMEM_RD_LO] = ~xmem_low;
assign pin_avail[`PPC_XMEM_WR_LO] = ~xmem_low;
assign pin_avail[15:8] = port1_digital_in;
assign pin_avail[31:16] = 16'hffff;

ppc_alloc #(
  .NS(`PPC_NUM_SLOTS),
  .NP(`PPC_LOW_PINS)
) u_alloc (
  .sys_clk(sys_clk),
  .rst(rst),
  .slot_en(slot_en),
  .pin_avail(pin_avail),
  .pin_owned(pin_owned),
  .pin_slot(pin_slot),
  .slot_pin(slot_pin),
  .slot_placed(slot_placed)
);

// ----------------------------------------
// pad input synchroniser
// ----------------------------------------
always @* begin
  // take the new level only once stages two and three agree
  next_pin_state = ((sync2 ~^ sync3) & sync3) |
    ((sync2 ^ sync3) & pin_state);
end

always @(posedge sys_clk) begin
  if (rst) begin
    sync1 <= `PPC_SYNC_RESET;
    sync2 <= `PPC_SYNC_RESET;
    sync3 <= `PPC_SYNC_RESET;
    pin_state <= `PPC_SYNC_RESET;
  end else begin
    sync1 <= pad_in;
    sync2 <= sync1;
    sync3 <= sync2;
    pin_state <= next_pin_state;
  end
end

// analog pins have no digital path and read as zero
assign pin_read = pin_state & ~analog_pins;

// ----------------------------------------
// port data latches
// ----------------------------------------
assign wmask = wr_en ? write_mask(wr_port, wr_bit_mode, wr_bit_sel) :
  64'h0000000000000000;
assign wdata_vec = wr_bit_mode ? {64{wr_data[0]}} : {8{wr_data}};

always @* begin
  next_latch = (latch & ~wmask) | (wdata_vec & wmask);
end

always @(posedge sys_clk) begin
  if (rst) begin
    latch <= `PPC_LATCH_RESET;
  end else begin
    latch <= next_latch;
  end
end

// ----------------------------------------
// read path
// ----------------------------------------
// rmw reads see the latch so owned bits are not rewritten
assign rd_byte = rd_rmw ? byte_of(latch, rd_port) :
  byte_of(pin_read, rd_port);

always @(posedge sys_clk) begin
  if (rst) begin
    rd_data <= 8'h00;
    rd_valid <= 1'b0;
  end else begin
    rd_valid <= rd_en;
    if (!rd_en) begin
      rd_data <= rd_data;
    end else if (!rd_bit_mode) begin
      rd_data <= rd_byte;
    end else if (rd_port < 3'h4) begin
      rd_data <= {7'h00, rd_byte[rd_bit_sel]};
    end else begin
      rd_data <= 8'h00;
    end
  end
end

// ----------------------------------------
// memory interface strobes
// ----------------------------------------
always @* begin
  xmem_here = 64'h0000000000000000;
  xmem_val = 64'hffffffffffffffff;
  if (ext_mem_enable && xmem_low) begin
    xmem_here[`PPC_XMEM_WR_LO] = 1'b1;
    xmem_here[`PPC_XMEM_RD_LO] = 1'b1;
    xmem_here[`PPC_XMEM_ALE_LO] = ext_mem_muxed;
    xmem_val[`PPC_XMEM_WR_LO] = ext_mem_wr_n;
    xmem_val[`PPC_XMEM_RD_LO] = ext_mem_rd_n;
    xmem_val[`PPC_XMEM_ALE_LO] = ext_mem_ale;
  end else if (ext_mem_enable) begin
    xmem_here[`PPC_XMEM_WR_UP] = 1'b1;
    xmem_here[`PPC_XMEM_RD_UP] = 1'b1;
    xmem_here[`PPC_XMEM_ALE_UP] = ext_mem_muxed;
    xmem_val[`PPC_XMEM_WR_UP] = ext_mem_wr_n;
    xmem_val[`PPC_XMEM_RD_UP] = ext_mem_rd_n;
    xmem_val[`PPC_XMEM_ALE_UP] = ext_mem_ale;
  end
end

// ----------------------------------------
// per-pin drive source
// ----------------------------------------
always @* begin
  sl = 5'h00;
  own = 1'b0;
  drv_val = 64'h0000000000000000;
  drv_req = 64'h0000000000000000;
  drv_od = 64'h0000000000000000;
  drv_gate = 64'h0000000000000000;
  for (p = 0; p < `PPC_ALL_PINS; p = p + 1) begin
    own = 1'b0;
    sl = 5'h00;
    if (p < `PPC_LOW_PINS) begin
      own = pin_owned[p];
      sl = pin_slot[p*5 +: 5];
    end
    if (xmem_here[p]) begin
      drv_val[p] = xmem_val[p];
      drv_req[p] = 1'b1;
      drv_od[p] = ~port_pushpull[p];
    end else if (own) begin
      // latch is ignored while a peripheral owns the pin
      drv_val[p] = periph_out[sl];
      drv_req[p] = ~in_mask[sl] & periph_drive[sl];
      drv_od[p] = od_mask[sl] | ~port_pushpull[p];
    end else begin
      drv_val[p] = latch[p];
      drv_req[p] = 1'b1;
      drv_od[p] = ~port_pushpull[p];
    end
    // lower drivers held off while config is still being written
    drv_gate[p] = (p < `PPC_LOW_PINS) ? xbar_en : 1'b1;
  end
end

generate
  for (g = 0; g < `PPC_ALL_PINS; g = g + 1) begin : g_pin
    ppc_pin_cell u_cell (
      .sys_clk(sys_clk),
      .rst(rst),
      .drv_val(drv_val[g]),
      .drv_req(drv_req[g]),
      .drv_od(drv_od[g]),
      .drv_gate(drv_gate[g]),
      .pu_disable(pu_disable),
      .analog(analog_pins[g]),
      .pad_out(pad_out[g]),
      .pad_oe(pad_oe[g]),
      .pad_pullup(pad_pullup[g])
    );
  end
endgenerate

// ----------------------------------------
// peripheral input return path
// ----------------------------------------
always @* begin
  next_periph_in = 28'hfffffff;
  for (s = 0; s < `PPC_NUM_SLOTS; s = s + 1) begin
    // unrouted inputs idle high, never see a pin
    if (slot_placed[s] && xbar_en) begin
      next_periph_in[s] = pin_read[slot_pin[s*5 +: 5]];
    end
  end
end

always @(posedge sys_clk) begin
  if (rst) begin
    periph_in <= 28'hfffffff;
    periph_routed <= 28'h0000000;
    second_adc_ain_sel <= 8'h00;
  end else begin
    periph_in <= next_periph_in;
    periph_routed <= slot_placed & {28{xbar_en}};
    second_adc_ain_sel <= ~port1_digital_in;
  end
end

endmodule // ppc_crossbar

// ---- bench/ppc_pads_model.sv ----
// board side of the pads: other drivers, pull-ups and floating lines
// assumes pad outputs of the crossbar and drive requests of the bench
`timescale 1ns/1ns
module ppc_pads_model (
  input wire sys_clk,
  input wire [63:0] pad_out,
  input wire [63:0] pad_oe,
  input wire [63:0] pad_pullup,
  input wire [63:0] ext_en,
  input wire [63:0] ext_val,
  output logic [63:0] pad_in
);
  logic [63:0] held = '1;
  // ------------------------------
  // pin resolution
  // ------------------------------
  always @* begin
    for (int i = 0; i < 64; i++) begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pullup[i])
        pad_in[i] = 1'b1;
      else
        pad_in[i] = ~held[i]; // floating: toggles, never a stale level
    end
  end
  always @(posedge sys_clk) held <= pad_in;
endmodule // ppc_pads_model

// ---- bench/ppc_crossbar_assertions.sv ----
// port-level checker for the priority pin crossbar
// assumes binding into ppc_crossbar, one clock, synchronous reset
`timescale 1ns/1ns
module ppc_crossbar_assertions (
  input wire sys_clk,
  input wire rst,
  input wire [7:0] crossbar_config_0,
  input wire [7:0] crossbar_config_2,
  input wire [63:0] port_pushpull,
  input wire [7:0] port1_digital_in,
  input wire rd_en,
  input wire [2:0] rd_port,
  input wire rd_bit_mode,
  input wire [7:0] rd_data,
  input wire rd_valid,
  input wire [27:0] periph_routed,
  input wire [7:0] second_adc_ain_sel,
  input wire [63:0] pad_out,
  input wire [63:0] pad_oe,
  input wire [63:0] pad_pullup
);
  wire xe = crossbar_config_2[6];
  wire s0 = crossbar_config_0[2];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ------------------------------
  // assertions
  // ------------------------------
  xbar_off_quiet_a: assert property ((!xe) [*3] |->
    pad_oe[31:0] == 32'h0 && periph_routed == 28'h0)
    else $error("lower pins active with crossbar off");
  serial0_fixed_a: assert property ((xe && s0) [*3] |->
    periph_routed[1:0] == 2'b11)
    else $error("serial 0 not on its fixed pins");
  serial0_off_a: assert property ((!s0) [*3] |->
    periph_routed[1:0] == 2'b00)
    else $error("disabled serial 0 still routed");
  whole_units_a: assert property (
    periph_routed[0] == periph_routed[1] &&
    periph_routed[8] == periph_routed[9] &&
    periph_routed[6] == periph_routed[7])
    else $error("serial peripheral partly routed");
  rx_no_drive_a: assert property (periph_routed[1] [*3] |->
    !pad_oe[1])
    else $error("receive pin driven");
  read_answer_a: assert property (rd_en |=> rd_valid)
    else $error("read not answered next cycle");
  read_single_a: assert property (!rd_en |=> !rd_valid)
    else $error("read answer without request");
  bit_read_a: assert property (rd_en && rd_bit_mode |=>
    rd_data[7:1] == 7'h0 && (!rd_port[2] || !rd_data[0]))
    else $error("bit read returned extra bits");
  pull_vs_low_a: assert property (
    (pad_oe & ~pad_out & pad_pullup) == 64'h0)
    else $error("pull-up on while driving low");
  pud_off_a: assert property (crossbar_config_2[7] [*3] |->
    pad_pullup == 64'h0)
    else $error("pull-up on while globally disabled");
  open_drain_a: assert property ($stable(port_pushpull) |->
    (pad_oe & pad_out & ~port_pushpull) == 64'h0)
    else $error("open-drain pin driven high");
  analog_sel_a: assert property (
    !$past(rst) && $stable(port1_digital_in) |->
    second_adc_ain_sel == ~port1_digital_in)
    else $error("analog select differs from port 1 mode");
  // ------------------------------
  // coverage
  // ------------------------------
  serial0_cov: cover property ((xe && s0) [*3]);
  bit_read_cov: cover property (rd_en && rd_bit_mode && rd_port[2]);
  pud_cov: cover property (crossbar_config_2[7] [*3]);
  lowest_cov: cover property (periph_routed[27]);
endmodule // ppc_crossbar_assertions
bind ppc_crossbar ppc_crossbar_assertions i_ppc_crossbar_assertions (.*);

// ---- bench/testbench.sv ----
// self-checking bench for the priority pin crossbar
// assumes ppc_crossbar, ppc_pads_model and the bound checker
`timescale 1ns/1ns
module testbench;
  logic sys_clk = 0, rst = 1;
  logic [7:0] crossbar_config_0 = 0, crossbar_config_1 = 0;
  logic [7:0] crossbar_config_2 = 0, port1_digital_in = 8'hff;
  logic [63:0] port_pushpull = 0, ext_en = 0, ext_val = 0, lat = '1;
  logic ext_mem_enable = 0, ext_mem_muxed = 0, ext_mem_ale = 0;
  logic ext_mem_wr_n = 1, ext_mem_rd_n = 1, rd_rmw = 0, rd_valid;
  logic wr_en = 0, wr_bit_mode = 0, rd_en = 0, rd_bit_mode = 0;
  logic [2:0] wr_port = 0, wr_bit_sel = 0, rd_port = 0, rd_bit_sel = 0;
  logic [7:0] wr_data = 0, rd_data, second_adc_ain_sel, e;
  logic [27:0] periph_out = 0, periph_drive = 0, periph_in, periph_routed;
  logic [63:0] pad_in, pad_out, pad_oe, pad_pullup;
  logic [31:0] seed = 32'hcf4d1491, r;
  logic [7:0] exp_q[$];
  int n_fail = 0, check_count = 0;
  int slot_of[8] = '{17, 18, 19, 20, 21, 22, 23, 26};

  ppc_crossbar i_ppc_crossbar (.*);
  ppc_pads_model i_ppc_pads_model (.*);

  always #25 sys_clk = ~sys_clk;
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [63:0] ev, gv);
    check_count++;
    if (gv !== ev) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, ev, gv);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // {oe, out} of a plain port pin
  function automatic logic [1:0] gpio(input int i);
    if (i < 32 && !crossbar_config_2[6]) return 2'b00;
    return port_pushpull[i] ? {1'b1, lat[i]} : {~lat[i], 1'b0};
  endfunction
  function automatic logic lvl(input int i);
    logic [1:0] g;
    g = gpio(i);
    return g[1] ? g[0] : ext_val[i];
  endfunction
  task automatic wr(input int p, input logic bm, input logic [2:0] b,
                    input logic [7:0] d);
    wr_port = p;
    wr_bit_mode = bm;
    wr_bit_sel = b;
    wr_data = d;
    wr_en = 1;
    if (!bm) lat[p*8 +: 8] = d;
    else if (p < 4) lat[p*8+b] = d[0];
    step(1);
    wr_en = 0;
    step(1);
  endtask
  task automatic rd(input int p, input logic bm, input logic [2:0] b,
                    input logic rmw, input logic [7:0] ev);
    rd_port = p;
    rd_bit_mode = bm;
    rd_bit_sel = b;
    rd_rmw = rmw;
    rd_en = 1;
    exp_q.push_back(ev);
    step(1);
    rd_en = 0;
    step(1);
  endtask
  task automatic pads(input logic [63:0] m);
    logic [63:0] eo, ed, ep;
    logic [1:0] g;
    for (int i = 0; i < 64; i++) begin
      g = gpio(i);
      eo[i] = g[1];
      ed[i] = g[0];
      ep[i] = !crossbar_config_2[7] && !(g[1] && !g[0]) &&
              !(i / 8 == 1 && !port1_digital_in[i % 8]);
    end
    chk("pad_oe", eo & m, pad_oe & m);
    chk("pad_out", ed & eo & m, pad_out & eo & m);
    chk("pad_pullup", ep & m, pad_pullup & m);
  endtask
  // other drivers only where the crossbar must not drive
  task automatic gpio_round();
    logic [1:0] g;
    ext_val = {rnd(), rnd()};
    for (int i = 0; i < 64; i++) begin
      g = gpio(i);
      ext_en[i] = ~g[1];
    end
    step(8);
    pads('1);
    chk("adc_sel", {~port1_digital_in}, second_adc_ain_sel);
    for (int p = 0; p < 8; p++) begin
      for (int k = 0; k < 8; k++) e[k] = lvl(p * 8 + k);
      if (p == 1) e = e & port1_digital_in;
      r = rnd();
      rd(p, 0, 0, 0, e);
      rd(p, 0, 0, 1, lat[p*8 +: 8]);
      rd(p, 1, r[2:0], 0, p < 4 ? {7'h0, e[r[2:0]]} : 8'h00);
    end
  endtask
  task automatic alloc(input logic [7:0] c0, c1, c2,
                       input logic [63:0] en, input logic [27:0] rt);
    crossbar_config_0 = c0;
    crossbar_config_1 = c1;
    crossbar_config_2 = c2;
    ext_en = en;
    ext_val = {rnd(), rnd()};
    step(8);
    chk("periph_routed", rt, periph_routed);
  endtask
  // ------------------------------
  // checking and watchdog
  // ------------------------------
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("rd_valid", 0, 1);
      else chk("rd_data", exp_q.pop_front(), rd_data);
    end
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 rst = 0;
    step(1);
    chk("pad_oe", 0, pad_oe);
    chk("pad_pullup", '1, pad_pullup);
    chk("rd_data", 0, rd_data);
    port_pushpull = {rnd(), rnd()};
    r = rnd();
    port1_digital_in = r[7:0];
    for (int p = 0; p < 8; p++) begin
      r = rnd();
      wr(p, 0, 0, r[7:0]);
    end
    wr(2, 1, 5, 8'h00);
    wr(4, 1, 3, {7'h0, ~lat[35]});
    gpio_round();
    crossbar_config_2 = 8'h40;
    gpio_round();
    crossbar_config_2 = 8'hc0;
    gpio_round();
    port_pushpull = '1;
    port1_digital_in = 8'hff;
    periph_drive = 28'h1;
    r = rnd();
    periph_out = r[27:0];
    wr(0, 0, 0, ~r[7:0]);
    alloc(8'h05, 0, 8'h40, 64'h0e, 28'h00000c3);
    chk("pad_oe", 64'h1, pad_oe[3:0]);
    chk("pad_out", periph_out[0], pad_out[0]);
    chk("periph_in", {ext_val[3:2], 4'hf, ext_val[1], periph_out[0]},
        periph_in[7:0]);
    chk("periph_in", 1, periph_in[27]);
    pads(64'hf0);
    rd(0, 0, 0, 0, {lat[7:4], ext_val[3:1], periph_out[0]});
    alloc(8'h01, 0, 8'h40, 64'h03, 28'h00000c0);
    chk("periph_in", {ext_val[1:0], 6'h3f}, periph_in[7:0]);
    for (int k = 0; k < 8; k++) begin
      alloc(8'h04, 8'h01 << k, 8'h40, 64'h6,
            28'h3 | 28'h1 << slot_of[k]);
    end
    alloc(8'h0c, 8'hff, 8'h5d, 64'hfffe, 28'hffe0703);
    chk("periph_in", ext_val[15], periph_in[27]);
    alloc(8'h04, 0, 8'h00, 64'hffffffff, 0);
    ext_mem_enable = 1;
    ext_mem_muxed = 1;
    r = rnd();
    {ext_mem_wr_n, ext_mem_rd_n, ext_mem_ale} = r[2:0];
    alloc(0, 0, 8'h42, 0, 0);
    chk("pad_out", r[2:0], pad_out[7:5]);
    chk("pad_oe", 3'h7, pad_oe[7:5]);
    alloc(0, 0, 8'h40, 0, 0);
    chk("pad_out", r[2:0], pad_out[39:37]);
    // non-muxed: the address strobe pin goes back to the crossbar
    ext_mem_muxed = 0;
    alloc(8'h04, 8'h3e, 8'h42, 64'h20, 28'h07c0003);
    chk("pad_oe", 3'h6, pad_oe[7:5]);
    chk("periph_in", ext_val[5], periph_in[21]);
    step(2);
    chk("exp_q", 0, exp_q.size());
    report_and_stop();
  end
endmodule // testbench
